// ===== src/cmw_card_memory_window_regs.sv
// Purpose: register bank for card memory window 3 and 4 and the extended index/data pair
// Assumes: one request per port per cycle; both ports share the storage
// Notes:   answers come one cycle after the request; config port wins a same-cycle clash
// How it works
// [R1] window 3 bit 7 enables write protect
// [R2] window 3 bit 6 picks attribute or common
// [R3] window 3 bits 5:0 give offset A25..A20
// [R4] extended index is an eight-bit read/write byte
// [R5] extended data byte carries selected extended register
// [R6] host avoids memory-space access to extended pair
// [R7] window 4 start low byte holds start A19..A12
// [R8] window 4 start-high bit 7 selects 16-bit width
// [R9] window 4 start-high bits 3:0 give A23..A20
// [R10] reserved start/end high bits read zero
// [R11] window 4 end low byte holds end low
// [R12] window 4 end-high bits 3:0 give A23..A20
// [R13] window 4 offset low byte holds offset low
// [R14] window 4 offset high mirrors window 3 layout
// [R15] window 3 offset low byte holds offset low
// [R16] reset clears every field to zero
// [R17] both offset paths reach identical register contents
`timescale 1ns/1ps
`include "cmw_consts.svh"

module cmw_card_memory_window_regs (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire cmw_pkg::cmw_preq_s pciReq,
	output cmw_pkg::cmw_resp_s      pciResp,
	input  wire cmw_pkg::cmw_lreq_s legReq,
	output cmw_pkg::cmw_resp_s      legResp,
	output cmw_pkg::cmw_win3_s      win3Cfg,
	output cmw_pkg::cmw_win4_s      win4Cfg,
	output logic      [7:0] extIndex,
	output logic      [7:0] extData,
	output logic            extDataWrite
);
	import cmw_pkg::*;

	localparam int NREG = `CMW_REG_COUNT;

	// bank positions, derived from the offsets
	localparam cmw_idx_t I_W3OL = 4'(`CMW_OFF_W3_OFF_LOW  - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W3OH = 4'(`CMW_OFF_W3_OFF_HIGH - `CMW_REG_FIRST);
	localparam cmw_idx_t I_EXTI = 4'(`CMW_OFF_EXT_INDEX   - `CMW_REG_FIRST);
	localparam cmw_idx_t I_EXTD = 4'(`CMW_OFF_EXTENDED_DATA    - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W4SL = 4'(`CMW_OFF_W4_STA_LOW  - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W4SH = 4'(`CMW_OFF_W4_STA_HIGH - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W4EL = 4'(`CMW_OFF_W4_END_LOW  - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W4EH = 4'(`CMW_OFF_W4_END_HIGH - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W4OL = 4'(`CMW_OFF_W4_OFF_LOW  - `CMW_REG_FIRST);
	localparam cmw_idx_t I_W4OH = 4'(`CMW_OFF_W4_OFF_HIGH - `CMW_REG_FIRST);

	// legacy offset to {hit, index}; used for both ports
	function automatic logic [4:0] offsetDecode(input logic [7:0] off);
		logic [7:0] rel;
		logic       inRange;
		rel     = off - `CMW_REG_FIRST;
		inRange = (off >= `CMW_REG_FIRST) && (rel < 8'(NREG));
		offsetDecode = {inRange, rel[3:0]};
	endfunction : offsetDecode

	// writable mask of a bank position; reserved bits stay zero
	function automatic logic [7:0] maskOf(input int pos);
		logic [7:0] m;
		m = `CMW_MASK_FULL;
		if (pos == int'(I_W4SH)) begin
			m = `CMW_MASK_STA_HIGH;         // see [R10]
		end else if (pos == int'(I_W4EH)) begin
			m = `CMW_MASK_END_HIGH;         // see [R10]
		end
		maskOf = m;
	endfunction : maskOf

	logic       pciHit;     // config offset mapped
	logic       legHit;     // legacy offset mapped
	cmw_idx_t   pciIdx;     // config target
	cmw_idx_t   legIdx;     // legacy target
	logic       pciWr;      // mapped config write
	logic       legWr;      // mapped legacy write
	logic [7:0] regVal [NREG];  // bank contents

	// address decode for both ports
	always_comb begin
		logic [4:0] pd;
		logic [4:0] ld;
		pd = offsetDecode(pciReq.addr[7:0]);
		ld = offsetDecode(legReq.offset);
		// the extended pair has no config offset; such accesses miss
		pciHit = pd[4] && (pciReq.addr[11:8] == `CMW_PCI_PAGE)
			&& (pd[3:0] != I_EXTI) && (pd[3:0] != I_EXTD);
		pciIdx = pd[3:0];
		legHit = ld[4];
		legIdx = ld[3:0];
		pciWr  = pciReq.req && pciReq.write && pciHit;
		legWr  = legReq.req && legReq.write && legHit;
	end

	// one shared store per register, so both paths agree by construction
	for (genvar g = 0; g < NREG; g++) begin : g_bank
		logic       wrEn;    // either port writes here
		logic [7:0] wrData;  // resolved byte
		// config port takes priority when both hit the same byte
		always_comb begin
			wrEn   = (pciWr && (pciIdx == 4'(g))) || (legWr && (legIdx == 4'(g)));  // see [R17]
			wrData = (pciWr && (pciIdx == 4'(g))) ? pciReq.wdata : legReq.wdata;
		end
		cmw_byte_reg #(
			.WMASK (maskOf(g))
		) u_reg (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.wrEn    (wrEn),
			.wrData  (wrData),
			.value   (regVal[g])
		);
	end

	cmw_resp_s next_pciResp;      // config answer
	cmw_resp_s next_legResp;      // legacy answer
	logic      next_extDataWrite; // extended data strobe

	// answers: read returns contents before any same-cycle write
	always_comb begin
		next_pciResp       = '0;
		next_legResp       = '0;
		next_pciResp.valid = pciReq.req;
		next_pciResp.hit   = pciHit;
		next_legResp.valid = legReq.req;
		next_legResp.hit   = legHit;
		// misses and writes answer zero
		if (pciReq.req && !pciReq.write && pciHit) begin
			next_pciResp.rdata = regVal[pciIdx];      // see [R17]
		end
		if (legReq.req && !legReq.write && legHit) begin
			next_legResp.rdata = regVal[legIdx];      // see [R17]
		end
		// tells the extended bank a new data byte arrived
		next_extDataWrite = legWr && (legIdx == I_EXTD);  // see [R5]
	end

	// answer registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pciResp      <= '0;   // see [R16]
			legResp      <= '0;
			extDataWrite <= 1'b0;
		end else begin
			pciResp      <= next_pciResp;
			legResp      <= next_legResp;
			extDataWrite <= next_extDataWrite;
		end
	end

	// extended pair, reachable only by legacy offset
	assign extIndex = regVal[I_EXTI];               // see [R4]
	assign extData  = regVal[I_EXTD];               // see [R5]

	// window 3 fields
	assign win3Cfg.writeProtect = regVal[I_W3OH][`CMW_BIT_WPROT];  // see [R1]
	assign win3Cfg.spaceSelect  = regVal[I_W3OH][`CMW_BIT_SPACE];  // see [R2]
	assign win3Cfg.offset = {regVal[I_W3OH][`CMW_OAH_MSB:0],       // see [R3]
		regVal[I_W3OL]};                                          // see [R15]

	// window 4 fields
	assign win4Cfg.dataWidth16 = regVal[I_W4SH][`CMW_BIT_WIDTH16]; // see [R8]
	assign win4Cfg.start = {regVal[I_W4SH][`CMW_SEH_MSB:0],        // see [R9]
		regVal[I_W4SL]};                                          // see [R7]
	assign win4Cfg.stop = {regVal[I_W4EH][`CMW_SEH_MSB:0],         // see [R12]
		regVal[I_W4EL]};                                          // see [R11]
	assign win4Cfg.writeProtect = regVal[I_W4OH][`CMW_BIT_WPROT];  // see [R14]
	assign win4Cfg.spaceSelect  = regVal[I_W4OH][`CMW_BIT_SPACE];  // see [R14]
	assign win4Cfg.offset = {regVal[I_W4OH][`CMW_OAH_MSB:0],       // see [R14]
		regVal[I_W4OL]};                                          // see [R13]

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// a config write to one legacy offset
	sequence pciWriteTo(logic [7:0] off);
		pciReq.req && pciReq.write && (pciReq.addr == {`CMW_PCI_PAGE, off});
	endsequence

	// a legacy write with no mapped config write in the same cycle
	sequence legWriteTo(logic [7:0] off);
		legReq.req && legReq.write && (legReq.offset == off) && !pciWr;
	endsequence

	// checked on the first edge that sees reset released; flops already cleared
	a_reset_clear: assert property (  // see [R16]
		$rose(rst_n) |-> (win3Cfg == '0) && (win4Cfg == '0)
			&& (extIndex == 8'h00) && (extData == 8'h00) && !pciResp.valid
			&& !legResp.valid && !extDataWrite)
		else $error("fields not clear after reset");

	a_wp3_follow: assert property (  // see [R1]
		pciWriteTo(`CMW_OFF_W3_OFF_HIGH) |=>
			win3Cfg.writeProtect == $past(pciReq.wdata[7]))
		else $error("window 3 write protect did not follow write");

	a_space3_follow: assert property (  // see [R2]
		legWriteTo(`CMW_OFF_W3_OFF_HIGH) |=>
			win3Cfg.spaceSelect == $past(legReq.wdata[6]))
		else $error("window 3 space select did not follow write");

	// after the load the field holds until the next write is taken
	a_off3_high: assert property (  // see [R3]
		pciWriteTo(`CMW_OFF_W3_OFF_HIGH) |=>
			win3Cfg.offset[13:8] == $past(pciReq.wdata[5:0]) ##1
			$stable(win3Cfg.offset[13:8]) || $past(pciWr || legWr))
		else $error("window 3 offset high wrong");

	a_ext_index: assert property (  // see [R4]
		legWriteTo(`CMW_OFF_EXT_INDEX) |=> extIndex == $past(legReq.wdata))
		else $error("extended index did not load");

	a_extended_data: assert property (  // see [R5]
		legWriteTo(`CMW_OFF_EXTENDED_DATA) |=> extDataWrite && (extData == $past(legReq.wdata)))
		else $error("extended data strobe or byte wrong");

	// neither byte of the extended pair may move through the config port
	a_ext_no_pci: assert property (  // see [R6]
		pciReq.req && !legWr && ((pciReq.addr == {`CMW_PCI_PAGE, `CMW_OFF_EXT_INDEX})
			|| (pciReq.addr == {`CMW_PCI_PAGE, `CMW_OFF_EXTENDED_DATA})) |=>
			pciResp.valid && !pciResp.hit && $stable(extIndex) && $stable(extData)
			&& !extDataWrite)
		else $error("extended pair reached by config offset");

	a_width4_follow: assert property (  // see [R8]
		pciWriteTo(`CMW_OFF_W4_STA_HIGH) |=>
			win4Cfg.dataWidth16 == $past(pciReq.wdata[7]))
		else $error("window 4 width did not follow write");

	a_rsvd_zero: assert property (  // see [R10]
		(regVal[I_W4SH][6:4] == 3'h0) && (regVal[I_W4EH][7:4] == 4'h0))
		else $error("reserved bit set");

	a_start4_full: assert property (  // see [R7] [R9]
		legWriteTo(`CMW_OFF_W4_STA_LOW) ##1 legWriteTo(`CMW_OFF_W4_STA_HIGH) |=>
			win4Cfg.start == {$past(legReq.wdata[3:0]), $past(legReq.wdata, 2)})
		else $error("window 4 start wrong");

	a_end4_full: assert property (  // see [R11] [R12]
		pciWriteTo(`CMW_OFF_W4_END_LOW) ##1 pciWriteTo(`CMW_OFF_W4_END_HIGH) |=>
			win4Cfg.stop == {$past(pciReq.wdata[3:0]), $past(pciReq.wdata, 2)})
		else $error("window 4 end wrong");

	a_off4_low: assert property (  // see [R13]
		legWriteTo(`CMW_OFF_W4_OFF_LOW) |=> win4Cfg.offset[7:0] == $past(legReq.wdata))
		else $error("window 4 offset low wrong");

	a_off4_high: assert property (  // see [R14]
		pciWriteTo(`CMW_OFF_W4_OFF_HIGH) |=>
			{win4Cfg.writeProtect, win4Cfg.spaceSelect, win4Cfg.offset[13:8]}
			== $past(pciReq.wdata))
		else $error("window 4 offset high wrong");

	a_off3_low: assert property (  // see [R15]
		legWriteTo(`CMW_OFF_W3_OFF_LOW) |=> win3Cfg.offset[7:0] == $past(legReq.wdata))
		else $error("window 3 offset low wrong");

	a_paths_match: assert property (  // see [R17]
		pciReq.req && !pciReq.write && pciHit && legReq.req && !legReq.write
			&& (legIdx == pciIdx) |=> pciResp.rdata == legResp.rdata)
		else $error("config and legacy reads differ");

	a_cross_path: assert property (  // see [R17]
		pciWriteTo(`CMW_OFF_W4_END_LOW) ##1 (legReq.req && !legReq.write
			&& (legReq.offset == `CMW_OFF_W4_END_LOW) && !pciWr && !legWr)
			|=> legResp.rdata == $past(pciReq.wdata, 2))
		else $error("legacy read misses config write");

	// a legacy miss answers but never claims a hit or returns data;
	// software probing past the bank must see a clean zero, not stale bytes
	a_leg_miss_zero: assert property (  // see [R17]
		legReq.req && !legHit |=>
			legResp.valid && !legResp.hit && (legResp.rdata == 8'h00))
		else $error("legacy miss answered with data");

	// a write answers with a zero byte; echoing the old value here
	// would let a host mistake the answer for the stored contents
	a_pci_write_zero: assert property (  // see [R17]
		pciReq.req && pciReq.write |=> pciResp.valid && (pciResp.rdata == 8'h00))
		else $error("config write answered with data");

	// reserved high bits of the end-high byte come back as zero on a read,
	// whatever software left in its write
	a_rsvd_read: assert property (  // see [R10]
		pciReq.req && !pciReq.write
			&& (pciReq.addr == {`CMW_PCI_PAGE, `CMW_OFF_W4_END_HIGH})
			|=> pciResp.rdata[7:4] == 4'h0)
		else $error("reserved bits read back set");

	// the strobe to the extended bank only ever follows a legacy data write;
	// a stray pulse would make the far side take a byte nobody sent
	a_ext_strobe_only: assert property (  // see [R5]
		extDataWrite |-> $past(legWr && (legIdx == I_EXTD)))
		else $error("extended strobe without a legacy data write");

	// each port answers exactly one cycle after it is asked and never twice,
	// so hosts may issue a request on every cycle
	a_answer_timing: assert property (  // see [R17]
		(pciResp.valid == $past(pciReq.req)) && (legResp.valid == $past(legReq.req)))
		else $error("answer strobe out of step with request");

endmodule : cmw_card_memory_window_regs

// ===== pkg/cmw_consts.svh
// Purpose: offsets, field positions, masks and reset values of the card memory window bank
// Assumes: byte-wide registers, legacy offset in the low byte of the config offset
// Notes:   definitions only, no logic
`ifndef CMW_CONSTS_SVH
`define CMW_CONSTS_SVH

// legacy indexed offsets of every register in the bank
`define CMW_OFF_W3_OFF_LOW   8'h2C
`define CMW_OFF_W3_OFF_HIGH  8'h2D
`define CMW_OFF_EXT_INDEX    8'h2E
`define CMW_OFF_EXTENDED_DATA     8'h2F
`define CMW_OFF_W4_STA_LOW   8'h30
`define CMW_OFF_W4_STA_HIGH  8'h31
`define CMW_OFF_W4_END_LOW   8'h32
`define CMW_OFF_W4_END_HIGH  8'h33
`define CMW_OFF_W4_OFF_LOW   8'h34
`define CMW_OFF_W4_OFF_HIGH  8'h35

// first offset and count of the contiguous bank
`define CMW_REG_FIRST        8'h2C
`define CMW_REG_COUNT        10

// config offsets are 0x8nn; upper nibble of the 12-bit offset
`define CMW_PCI_PAGE         4'h8

// writable-bit masks; zero bits are reserved and read 0
`define CMW_MASK_FULL        8'hFF
`define CMW_MASK_STA_HIGH    8'h8F
`define CMW_MASK_END_HIGH    8'h0F

// every field clears on reset
`define CMW_RESET_BYTE       8'h00

// field positions
`define CMW_BIT_WPROT        7
`define CMW_BIT_SPACE        6
`define CMW_BIT_WIDTH16      7
`define CMW_OAH_MSB          5
`define CMW_SEH_MSB          3

`endif

// ===== pkg/cmw_pkg.sv
// Purpose: types shared by the card memory window bank and its users
// Assumes: cmw_consts.svh gives the numbers
// Notes:   requests and answers travel as packed structs
package cmw_pkg;

	typedef logic [3:0] cmw_idx_t;     // index into the bank

	// config-offset access request
	typedef struct packed {
		logic        req;                // one-cycle request strobe
		logic        write;              // 1 write, 0 read
		logic [11:0] addr;               // config offset
		logic [7:0]  wdata;              // write byte
	} cmw_preq_s;

	// legacy indexed access request
	typedef struct packed {
		logic        req;                // one-cycle request strobe
		logic        write;              // 1 write, 0 read
		logic [7:0]  offset;             // legacy offset
		logic [7:0]  wdata;              // write byte
	} cmw_lreq_s;

	// answer, one cycle after the request
	typedef struct packed {
		logic        valid;              // answer strobe
		logic        hit;                // offset was mapped
		logic [7:0]  rdata;              // read byte, 0 for writes and misses
	} cmw_resp_s;

	// window 3 settings seen by the decode datapath
	typedef struct packed {
		logic        writeProtect;       // 1 protect
		logic        spaceSelect;        // 1 attribute, 0 common
		logic [13:0] offset;             // {A25..A20, low byte}
	} cmw_win3_s;

	// window 4 settings seen by the decode datapath
	typedef struct packed {
		logic        dataWidth16;        // 1 16-bit, 0 8-bit
		logic [11:0] start;              // {A23..A20, low byte}
		logic [11:0] stop;               // {A23..A20, low byte}
		logic        writeProtect;       // 1 protect
		logic        spaceSelect;        // 1 attribute, 0 common
		logic [13:0] offset;             // {A25..A20, low byte}
	} cmw_win4_s;

endpackage : cmw_pkg

// ===== src/cmw_byte_reg.sv
// Purpose: one byte register with a writable mask
// Assumes: write enable and data already resolved by the bank
// Notes:   masked-off bits hold zero and so read zero
`timescale 1ns/1ps
`include "cmw_consts.svh"

module cmw_byte_reg #(
	parameter logic [7:0] WMASK = `CMW_MASK_FULL  // writable bits
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	output logic      [7:0] value
);
	import cmw_pkg::*;

	logic [7:0] next_value;   // value after this edge

	// masked load; reserved bits never take a one
	always_comb begin
		next_value = value;
		if (wrEn) begin
			next_value = wrData & WMASK;
		end
	end

	// register; synchronous clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			value <= `CMW_RESET_BYTE;
		end else begin
			value <= next_value;
		end
	end

endmodule : cmw_byte_reg

// ===== dv/cmw_ext_model.sv
// Purpose: stand-in for the extended register bank behind the index/data pair
// Assumes: one write pulse per legacy write to the data byte
// Notes:   keeps only the last index/data pair and a write count
`timescale 1ns/1ps

module cmw_ext_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [7:0] extIndex,
	input  wire logic [7:0] extData,
	input  wire logic       extDataWrite,
	output logic      [7:0] lastIndex,
	output logic      [7:0] lastData,
	output logic      [3:0] writeCount
);
	// capture on the pulse; the index must already be set by then
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lastIndex  <= 8'h00;
			lastData   <= 8'h00;
			writeCount <= 4'h0;
		end else if (extDataWrite) begin
			lastIndex  <= extIndex;
			lastData   <= extData;
			writeCount <= writeCount + 4'h1;
		end
	end
endmodule : cmw_ext_model

// ===== dv/tb.sv
// Purpose: self-checking bench for the card memory window register bank
// Assumes: one-cycle answers on both ports, config port wins a clash
// Notes:   memory-space accesses to the extended pair are issued and must miss
`timescale 1ns/1ps
`include "cmw_consts.svh"

module tb;
	import cmw_pkg::*;
	logic       clk_sys;      // 10 MHz
	logic       rst_n;        // synchronous, active low
	cmw_preq_s  pciReq;       // config port request
	cmw_resp_s  pciResp;      // config port answer
	cmw_lreq_s  legReq;       // legacy port request
	cmw_resp_s  legResp;      // legacy port answer
	cmw_win3_s  win3Cfg;      // window 3 settings
	cmw_win4_s  win4Cfg;      // window 4 settings
	logic [7:0] extIndex;     // extended index
	logic [7:0] extData;      // extended data
	logic       extDataWrite; // extended write pulse
	logic [7:0] lastIndex;    // model capture
	logic [7:0] lastData;     // model capture
	logic [3:0] writeCount;   // model write count
	int         fails = 0;    // mismatches
	int         compares = 0; // comparisons made
	int         cycles = 0;   // timeout counter
	// rows: port(1 legacy), write, offset, data, hit, expected read byte
	localparam logic [35:0] ROWS [24] = '{
		36'h1_1_2C_A5_1_00, 36'h0_0_2C_00_1_A5,
		36'h1_1_2D_C3_1_00, 36'h0_0_2D_00_1_C3,
		36'h1_1_2E_5A_1_00, 36'h1_0_2E_00_1_5A,
		36'h0_1_2E_FF_0_00, 36'h1_0_2E_00_1_5A,
		36'h1_1_2F_96_1_00, 36'h1_0_2F_00_1_96,
		36'h0_1_30_3C_1_00, 36'h1_0_30_00_1_3C,
		36'h0_1_31_8F_1_00, 36'h1_0_31_00_1_8F,
		36'h1_1_32_E1_1_00, 36'h0_0_32_00_1_E1,
		36'h1_1_33_0F_1_00, 36'h0_0_33_00_1_0F,
		36'h1_1_34_7E_1_00, 36'h0_0_34_00_1_7E,
		36'h0_1_35_81_1_00, 36'h1_0_35_00_1_81,
		36'h1_1_36_FF_0_00, 36'h0_0_2B_00_0_00  // outside the bank
	};

	cmw_card_memory_window_regs dut_u (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.pciReq      (pciReq),
		.pciResp     (pciResp),
		.legReq      (legReq),
		.legResp     (legResp),
		.win3Cfg     (win3Cfg),
		.win4Cfg     (win4Cfg),
		.extIndex    (extIndex),
		.extData     (extData),
		.extDataWrite(extDataWrite)
	);

	cmw_ext_model model_u (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.extIndex    (extIndex),
		.extData     (extData),
		.extDataWrite(extDataWrite),
		.lastIndex   (lastIndex),
		.lastData    (lastData),
		.writeCount  (writeCount)
	);

	// free-running clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// one compare; case inequality so unknowns never match
	task automatic chk(input string name, input logic [40:0] seen, input logic [40:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// counts, verdict, end of run
	task automatic conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	// one access on either port, answer checked the cycle after it is taken
	task automatic op(input logic p, input logic w, input logic [7:0] off,
		input logic [7:0] d, input logic h, input logic [7:0] e);
		cmw_resp_s r;
		@(posedge clk_sys);
		if (p) begin
			legReq <= '{1'b1, w, off, d};
		end else begin
			pciReq <= '{1'b1, w, {`CMW_PCI_PAGE, off}, d};
		end
		@(posedge clk_sys);
		pciReq <= '0;
		legReq <= '0;
		#1;
		r = p ? legResp : pciResp;
		chk("valid", r.valid, 1'b1);
		chk("hit", r.hit, h);
		chk("rdata", r.rdata, e);
		chk("extDataWrite", extDataWrite, p & w & (off == `CMW_OFF_EXTENDED_DATA));
	endtask : op

	// every register reads zero on both ports, settings all cleared
	task automatic resetCheck(input string name);
		logic [7:0] off;
		for (int i = 0; i < `CMW_REG_COUNT; i++) begin
			for (int j = 0; j < 2; j++) begin
				off = `CMW_REG_FIRST + 8'(i);
				op(j[0], 1'b0, off, 8'h00, j[0] | (i != 2 && i != 3), 8'h00);
			end
		end
		chk("win3Cfg", win3Cfg, '0);
		chk("win4Cfg", win4Cfg, '0);
		chk("extIndex", {extIndex, extData}, '0);
		$display("test %s done", name);
	endtask : resetCheck

	// hang guard; the run needs about 150 cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails++;
			conclude();
		end
	end

	// main sequence
	initial begin
		pciReq = '0;
		legReq = '0;
		rst_n  = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		resetCheck("reset values");
		foreach (ROWS[k]) begin
			op(ROWS[k][32], ROWS[k][28], ROWS[k][27:20], ROWS[k][19:12], ROWS[k][8], ROWS[k][7:0]);
		end
		chk("win3Cfg", win3Cfg, 16'hC3A5);
		chk("win4Cfg", win4Cfg, {1'b1, 12'hF3C, 12'hFE1, 1'b1, 1'b0, 14'h017E});
		chk("extIndex", extIndex, 8'h5A);
		chk("extData", extData, 8'h96);
		chk("model", {lastIndex, lastData, writeCount}, {8'h5A, 8'h96, 4'h1});
		$display("test table done");
		// same-cycle clash, then a back-to-back read of the same byte
		@(posedge clk_sys);
		pciReq <= '{1'b1, 1'b1, 12'h82C, 8'h11};
		legReq <= '{1'b1, 1'b1, 8'h2C, 8'h22};
		@(posedge clk_sys);
		pciReq <= '{1'b1, 1'b0, 12'h82C, 8'h00};
		legReq <= '0;
		@(posedge clk_sys);
		pciReq <= '0;
		#1;
		chk("clash", pciResp.rdata, 8'h11);
		$display("test clash done");
		// back-to-back writes on each port, then one byte read on both at once
		@(posedge clk_sys);
		pciReq <= '{1'b1, 1'b1, 12'h82D, 8'h4A};
		@(posedge clk_sys);
		pciReq <= '0;
		legReq <= '{1'b1, 1'b1, 8'h30, 8'h11};
		@(posedge clk_sys);
		legReq <= '{1'b1, 1'b1, 8'h31, 8'h05};
		@(posedge clk_sys);
		legReq <= '0;
		pciReq <= '{1'b1, 1'b1, 12'h832, 8'h22};
		@(posedge clk_sys);
		pciReq <= '{1'b1, 1'b1, 12'h833, 8'h07};
		@(posedge clk_sys);
		pciReq <= '{1'b1, 1'b1, 12'h832, 8'h33};
		@(posedge clk_sys);
		pciReq <= '{1'b1, 1'b0, 12'h832, 8'h00};
		legReq <= '{1'b1, 1'b0, 8'h32, 8'h00};
		@(posedge clk_sys);
		pciReq <= '0;
		legReq <= '0;
		#1;
		chk("dualRead", {pciResp.rdata, legResp.rdata}, 16'h3333);
		chk("win3Cfg", win3Cfg, 16'h4A11);
		chk("start", win4Cfg.start, 12'h511);
		chk("stop", win4Cfg.stop, 12'h733);
		chk("dataWidth16", win4Cfg.dataWidth16, 1'b0);
		$display("test back-to-back done");
		// second reset in mid-run
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		resetCheck("mid-run reset");
		conclude();
	end
endmodule : tb
